// ---- core/tsc_core.sv ----
// Precision temperature sensor control, timing and result registers
`timescale 1ns/1ns
module tsc_core #(
  parameter longint SENSOR_CLK_FREQ_HZ = tsc_pkg::SENSOR_CLK_FREQ_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Special function register access
  input wire tsc_pkg::tsc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Sensing element word, valid at end of measurement
  input wire logic [15:0] sensor_word,
  // Interrupt enable bit and request
  input wire logic temp_irq_enable,
  output logic temp_irq_req
);

  // ****************************************************************
  // Derived timing
  // ****************************************************************
  // Clock cycles per length unit of 256 sensor clocks
  localparam int UNIT_CYC = int'(tsc_pkg::UNIT_SENSOR_CLKS * tsc_pkg::CLK_HZ
                                 / SENSOR_CLK_FREQ_HZ);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic ctrl_sel;  // Control register addressed
  logic lo_sel;    // Result low byte addressed
  logic hi_sel;    // Result high byte addressed
  logic ctrl_wr;   // Write to control
  logic trig_fall; // Trigger written from one to zero
  logic finish;    // Last cycle of a measurement

  assign ctrl_sel = (sfr_req.addr == tsc_pkg::CTRL_ADDR) && (sfr_req.page == tsc_pkg::CTRL_PAGE);
  assign lo_sel = (sfr_req.addr == tsc_pkg::WORD_LO_ADDR) && (sfr_req.page == tsc_pkg::WORD_PAGE);
  assign hi_sel = (sfr_req.addr == tsc_pkg::WORD_HI_ADDR) && (sfr_req.page == tsc_pkg::WORD_PAGE);
  assign ctrl_wr = sfr_req.wr && ctrl_sel;

  // ****************************************************************
  // State
  // ****************************************************************
  logic trig_q, trig_d;             // Measure trigger bit
  logic done_q, done_d;             // Measure done flag
  logic [2:0] conv_q, conv_d;       // Conversion length select
  logic [15:0] word_q, word_d;      // Result word
  logic [7:0] rdata_q, rdata_d;     // Read data
  tsc_pkg::tsc_state_t st_q, st_d;  // Sequencer state
  logic [31:0] div_q, div_d;        // Unit divider
  logic [8:0] unit_q, unit_d;       // Units elapsed
  logic [8:0] unit_tgt;             // Units to run, 2^(N+1)+1
  logic [12:0] tail_q, tail_d;      // Tail cycles elapsed
  logic unit_tick;                  // One-cycle enable per length unit

  // Firmware writes one then zero; a fall is what starts a measurement
  assign trig_fall = ctrl_wr && trig_q && !sfr_req.wdata[tsc_pkg::TRIG_BIT];
  assign unit_tgt = 9'((9'h002 << conv_q) + 9'h001);
  assign unit_tick = (st_q == tsc_pkg::ST_UNITS) && (div_q == 32'(UNIT_CYC - 1));
  assign finish = (st_q == tsc_pkg::ST_TAIL) && (tail_q == 13'(tsc_pkg::TAIL_CYC - 1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Registers, sequencer and read path
  always_comb begin
    trig_d = trig_q;
    done_d = done_q;
    conv_d = conv_q;
    word_d = word_q;
    rdata_d = rdata_q;
    st_d = st_q;
    div_d = div_q;
    unit_d = unit_q;
    tail_d = tail_q;
    // Control writes; reserved bits are dropped
    if (ctrl_wr) begin
      trig_d = sfr_req.wdata[tsc_pkg::TRIG_BIT];
      conv_d = sfr_req.wdata[tsc_pkg::CONV_MSB:tsc_pkg::CONV_LSB];
      // Writing zero clears the flag; writing one has no effect
      if (!sfr_req.wdata[tsc_pkg::DONE_BIT]) begin
        done_d = 1'b0;
      end
    end
    // Result bytes are writable by firmware
    if (sfr_req.wr && lo_sel) begin
      word_d[7:0] = sfr_req.wdata;
    end
    if (sfr_req.wr && hi_sel) begin
      word_d[15:8] = sfr_req.wdata;
    end
    // Sequencer
    unique case (st_q)
      tsc_pkg::ST_IDLE: begin
        // Only the falling trigger starts; a held one does nothing
        if (trig_fall) begin
          st_d = tsc_pkg::ST_UNITS;
          div_d = 32'h0000_0000;
          unit_d = 9'h000;
        end
      end
      tsc_pkg::ST_UNITS: begin
        // Count length units of 256 sensor clocks each
        div_d = unit_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
        if (unit_tick) begin
          unit_d = unit_q + 9'h001;
          if (unit_q + 9'h001 == unit_tgt) begin
            st_d = tsc_pkg::ST_TAIL;
            tail_d = 13'h0000;
          end
        end
      end
      tsc_pkg::ST_TAIL: begin
        // Fixed 32 us tail, then capture and flag
        tail_d = tail_q + 13'h0001;
        if (finish) begin
          st_d = tsc_pkg::ST_IDLE;
          // Sensor word is already sign, 8 integer and 7 fraction bits
          word_d = sensor_word;
          // Setting wins over a firmware clear in the same cycle
          done_d = 1'b1;
        end
      end
    endcase
    // Read data; unmapped reads return zero
    if (sfr_req.rd) begin
      if (ctrl_sel) begin
        rdata_d = {trig_q, done_q, 3'h0, conv_q};
      end else if (hi_sel) begin
        rdata_d = word_q[15:8];
      end else if (lo_sel) begin
        rdata_d = word_q[7:0];
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trig_q <= tsc_pkg::CTRL_RESET[tsc_pkg::TRIG_BIT];
      done_q <= tsc_pkg::CTRL_RESET[tsc_pkg::DONE_BIT];
      conv_q <= tsc_pkg::CTRL_RESET[tsc_pkg::CONV_MSB:tsc_pkg::CONV_LSB];
      word_q <= {tsc_pkg::WORD_RESET, tsc_pkg::WORD_RESET};
      rdata_q <= 8'h00;
      st_q <= tsc_pkg::ST_IDLE;
      div_q <= 32'h0000_0000;
      unit_q <= 9'h000;
      tail_q <= 13'h0000;
    end else begin
      trig_q <= trig_d;
      done_q <= done_d;
      conv_q <= conv_d;
      word_q <= word_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      div_q <= div_d;
      unit_q <= unit_d;
      tail_q <= tail_d;
    end
  end

  // Outputs: read data from flop, interrupt gated by enable
  assign sfr_rdata = rdata_q;
  assign temp_irq_req = done_q && temp_irq_enable;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_FALL_STARTS: assert property (
    (st_q == tsc_pkg::ST_IDLE) && trig_fall |=> (st_q == tsc_pkg::ST_UNITS) && (unit_q == 9'h000))
    else $error("trigger fall did not start a measurement");
  AST_HOLD_NO_START: assert property (
    (st_q == tsc_pkg::ST_IDLE) && !trig_fall |=> (st_q == tsc_pkg::ST_IDLE))
    else $error("measurement started without a trigger fall");
  AST_UNITS_LEN: assert property (
    (st_q == tsc_pkg::ST_UNITS) ##1 (st_q == tsc_pkg::ST_TAIL)
      |-> ($past(unit_q) + 9'h001 == unit_tgt))
    else $error("wrong number of length units");
  AST_TAIL_HOLD: assert property (
    (st_q == tsc_pkg::ST_TAIL) && (tail_q < 13'(tsc_pkg::TAIL_CYC - 1))
      |=> (st_q == tsc_pkg::ST_TAIL))
    else $error("tail ended early");
  AST_DONE_SET: assert property (
    finish |=> done_q && (st_q == tsc_pkg::ST_IDLE))
    else $error("done flag not set at completion");
  AST_DONE_STICKY: assert property (
    done_q && !(ctrl_wr && !sfr_req.wdata[tsc_pkg::DONE_BIT]) |=> done_q)
    else $error("done flag cleared without firmware");
  AST_RESULT_CAPTURE: assert property (
    finish |=> (word_q == $past(sensor_word)))
    else $error("result word not captured");
  AST_HI_BYTE: assert property (
    sfr_req.rd && hi_sel |=> (sfr_rdata == $past(word_q[15:8])))
    else $error("high byte read mismatch");
  AST_IRQ_RISE: assert property (
    finish && temp_irq_enable |=> temp_irq_req)
    else $error("interrupt not raised on done");
  AST_IRQ_MASKED: assert property (
    !temp_irq_enable |-> !temp_irq_req)
    else $error("interrupt raised while disabled");

  COV_START: cover property ((st_q == tsc_pkg::ST_IDLE) && trig_fall);
  COV_FINISH: cover property (finish);
  COV_IRQ: cover property ($rose(temp_irq_req));
  COV_NEG_WORD: cover property (finish && sensor_word == 16'hEC00);

endmodule : tsc_core

// ---- core/tsc_pkg.sv ----
// Package with register map, field layout, timing constants and types of the temperature sensor
package tsc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'hD2;     // Control register address
  localparam logic [3:0] CTRL_PAGE = 4'hF;      // Control register page
  localparam logic [7:0] WORD_LO_ADDR = 8'hD2;  // Result low byte address
  localparam logic [7:0] WORD_HI_ADDR = 8'hD3;  // Result high byte address
  localparam logic [3:0] WORD_PAGE = 4'h0;      // Result byte page
  localparam logic [7:0] CTRL_RESET = 8'h00;    // Control reset value
  localparam logic [7:0] WORD_RESET = 8'h00;    // Result byte reset value

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int TRIG_BIT = 7;                  // Measure trigger bit
  localparam int DONE_BIT = 6;                  // Measure done flag
  localparam int CONV_MSB = 2;                  // Conversion length select, top bit
  localparam int CONV_LSB = 0;                  // Conversion length select, low bit

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 125_000_000;      // Reference clock rate
  localparam longint UNIT_SENSOR_CLKS = 256;    // Sensor clocks per length unit
  localparam longint TAIL_US = 32;              // Fixed tail of every measurement
  localparam int TAIL_CYC = int'(TAIL_US * CLK_HZ / 1_000_000); // Tail in clock cycles
  localparam longint SENSOR_CLK_FREQ_DEF = 1_000_000; // Plain default sensor clock rate

  // ****************************************************************
  // Types
  // ****************************************************************
  // One special function register access
  typedef struct packed {
    logic [7:0] addr;   // Register address
    logic [3:0] page;   // Register page
    logic wr;           // Write strobe
    logic rd;           // Read strobe
    logic [7:0] wdata;  // Write data
  } tsc_sfr_req_t;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_UNITS,
    ST_TAIL
  } tsc_state_t;

endpackage : tsc_pkg

// ---- tb/tsc_core_test.sv ----
// Self-checking bench for the temperature sensor control block
`timescale 1ns/1ns
module tsc_core_test;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam longint FREQ = 64'd4_000_000_000;  // Gives eight clocks per length unit
  localparam int UNIT = 8;                       // Clocks per length unit at FREQ
  logic ref_clk;                                 // Bench clock
  logic nrst;                                    // Synchronous reset, active low
  tsc_pkg::tsc_sfr_req_t req;                    // Register access request
  logic [7:0] sfr_rdata;                         // Register read data
  logic [15:0] sensor_word;                      // Word from the sensing element
  logic temp_irq_enable;                         // Interrupt enable bit
  logic temp_irq_req;                            // Interrupt request
  int fail_count;                                // Mismatches seen
  int n_tests;                                   // Comparisons made
  logic [7:0] rv;                                // Last read value
  // Example words, one for each conversion length
  logic [15:0] words [8] = '{16'h3480, 16'h1400, 16'h0CE0, 16'h0080,
                             16'h0040, 16'h0001, 16'hFFFF, 16'hEC00};

  tsc_core #(.SENSOR_CLK_FREQ_HZ(FREQ)) DUT (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(req),
    .sfr_rdata(sfr_rdata), .sensor_word(sensor_word), .temp_irq_enable(temp_irq_enable),
    .temp_irq_req(temp_irq_req));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare and report one value
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Print counts and verdict, then stop
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // One-cycle write strobe, then one idle cycle so that a following write sees a gap
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    req.addr = a;
    req.page = p;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge ref_clk);
    req.wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr_reg
  // One-cycle read strobe; data is taken one cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, input logic [3:0] p);
    req.addr = a;
    req.page = p;
    req.rd = 1'b1;
    @(negedge ref_clk);
    req.rd = 1'b0;
    @(negedge ref_clk);
    rv = sfr_rdata;
  endtask : rd_reg
  // Full measurement of length n, optionally holding the trigger high first
  task automatic measure(input int n, input int hold);
    int cyc;
    int exp;
    exp = ((2 ** (n + 1)) + 1) * UNIT + tsc_pkg::TAIL_CYC;
    sensor_word = words[n];
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, 8'h80 | n[7:0]);
    if (hold > 0) begin
      repeat (hold) @(negedge ref_clk);
      rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
      check("held trigger ctrl", {8'h00, 8'h80 | n[7:0]}, {8'h00, rv});
    end
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, n[7:0]);
    cyc = 0;
    while (temp_irq_req !== 1'b1 && cyc < 20000) begin
      @(negedge ref_clk);
      cyc++;
    end
    // Counting begins one idle cycle after the start edge; the request shows a half cycle late
    check("duration", 16'(exp - 1), 16'(cyc));
    rd_reg(tsc_pkg::WORD_HI_ADDR, tsc_pkg::WORD_PAGE);
    check("high byte", {8'h00, words[n][15:8]}, {8'h00, rv});
    rd_reg(tsc_pkg::WORD_LO_ADDR, tsc_pkg::WORD_PAGE);
    check("low byte", {8'h00, words[n][7:0]}, {8'h00, rv});
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("done ctrl", {8'h00, 8'h40 | n[7:0]}, {8'h00, rv});
    temp_irq_enable = 1'b0;
    @(negedge ref_clk);
    check("masked irq", 16'h0000, {15'h0000, temp_irq_req});
    temp_irq_enable = 1'b1;
    @(negedge ref_clk);
    check("unmasked irq", 16'h0001, {15'h0000, temp_irq_req});
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, 8'h40 | n[7:0]);
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("done after write one", {8'h00, 8'h40 | n[7:0]}, {8'h00, rv});
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, n[7:0]);
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("done cleared", {8'h00, n[7:0]}, {8'h00, rv});
    check("irq cleared", 16'h0000, {15'h0000, temp_irq_req});
    $display("test measure length %0d done", n);
  endtask : measure

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #(8 * 90000);
    fail_count++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    req = '0;
    sensor_word = 16'h0000;
    temp_irq_enable = 1'b1;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    // Reset values, unmapped read, result byte storage, reserved bits
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("ctrl reset", {8'h00, tsc_pkg::CTRL_RESET}, {8'h00, rv});
    rd_reg(tsc_pkg::WORD_HI_ADDR, tsc_pkg::WORD_PAGE);
    check("high reset", {8'h00, tsc_pkg::WORD_RESET}, {8'h00, rv});
    rd_reg(8'hD3, 4'hF);
    check("unmapped read", 16'h0000, {8'h00, rv});
    wr_reg(tsc_pkg::WORD_LO_ADDR, tsc_pkg::WORD_PAGE, 8'h5A);
    rd_reg(tsc_pkg::WORD_LO_ADDR, tsc_pkg::WORD_PAGE);
    check("low byte store", 16'h005A, {8'h00, rv});
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, 8'h7D);
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("reserved and done read", 16'h0005, {8'h00, rv});
    $display("test reset and access done");
    // Held trigger, then every conversion length with an example word
    measure(0, 4100);
    for (int n = 1; n < 8; n++) measure(n, 0);
    // Reset in mid-measurement returns the sequencer to idle
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, 8'h80);
    wr_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE, 8'h00);
    repeat (100) @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4100) @(negedge ref_clk);
    check("irq after reset", 16'h0000, {15'h0000, temp_irq_req});
    rd_reg(tsc_pkg::CTRL_ADDR, tsc_pkg::CTRL_PAGE);
    check("ctrl after reset", 16'h0000, {8'h00, rv});
    $display("test mid-run reset done");
    conclude();
  end
endmodule : tsc_core_test
